// >>> rtl/gpb_map.vh
// Register offsets, field positions and reset values of the port slice
`ifndef GPB_MAP_VH
`define GPB_MAP_VH
// ==========================================================
// Register indices (byte address is four times the index)
`define GPB_IDX_PORTA_LATCH 8'h00
`define GPB_IDX_PORTB_LATCH 8'h01
`define GPB_IDX_PORTC_LATCH 8'h02
`define GPB_IDX_PORTB_LED 8'h0C
`define GPB_IDX_PORTA_DIR 8'h20
`define GPB_IDX_PORTB_DIR 8'h21
`define GPB_IDX_PORTC_DIR 8'h22
`define GPB_IDX_ALT_CTRL 8'h23
// ==========================================================
// Field positions in the alternate-function control register
`define GPB_ALT_SERIAL_ON 0
`define GPB_ALT_TIMER1_CHANNEL0_PIN 1
`define GPB_ALT_TIMER1_CHANNEL1_PIN 2
`define GPB_ALT_TIMER2_CHANNEL0_PIN 3
`define GPB_ALT_TIMER2_CHANNEL1_PIN 4
`define GPB_ALT_LCD_LOWER 5
`define GPB_ALT_LCD_UPPER 6
// ==========================================================
// Reset values and widths, and the ADC channel codes that claim port B pins 6 and 7
`define GPB_DIR_RESET 8'h00
`define GPB_LED_RESET 6'h00
`define GPB_ALT_RESET 7'h00
`define GPB_ADC_CH4 5'h04
`define GPB_ADC_CH5 5'h05
`endif

// >>> rtl/gpb_pin_sync.v
// Two-flop synchroniser for a bank of pin inputs
`timescale 1ns/10ps
module gpb_pin_sync #(
   parameter WIDTH = 8
) (
   clk,
   din,
   dout
);
   input wire clk;
   input wire [WIDTH-1:0] din;
   output reg [WIDTH-1:0] dout;

   reg [WIDTH-1:0] meta_q;

   // ==========================================================
   // Synchroniser
   // First stage read only by the second; no reset so pins never glitch it
   always @(posedge clk)
   begin
      meta_q <= din;
      dout <= meta_q;
   end
endmodule

// >>> rtl/gpb_port_slice.v
// Port A/B/C general-purpose I/O slice with APB register access
`timescale 1ns/10ps
`include "gpb_map.vh"

module gpb_port_slice #(
   parameter ADDR_WIDTH = 12
) (
   clk,
   sys_rst,
   psel,
   penable,
   pwrite,
   paddr,
   pwdata,
   prdata,
   pready,
   pslverr,
   portAIn,
   portAOut,
   portAOe,
   portBIn,
   portBOut,
   portBOe,
   portBHighSink,
   portBAnalog,
   portCIn,
   portCOut,
   portCOe,
   serialTxData,
   serialRxData,
   timerChanOut,
   timerChanOe,
   timerChanIn,
   analogChannelSelect,
   lcdFrontplaneOut
);
   input wire clk;
   input wire sys_rst;
   input wire psel;
   input wire penable;
   input wire pwrite;
   input wire [ADDR_WIDTH-1:0] paddr;
   input wire [31:0] pwdata;
   output reg [31:0] prdata;
   output wire pready;
   output wire pslverr;
   input wire [7:0] portAIn;
   output reg [7:0] portAOut;
   output reg [7:0] portAOe;
   input wire [7:0] portBIn;
   output reg [7:0] portBOut;
   output reg [7:0] portBOe;
   output reg [7:0] portBHighSink;
   output reg [1:0] portBAnalog;
   input wire [7:0] portCIn;
   output reg [7:0] portCOut;
   output reg [7:0] portCOe;
   input wire serialTxData;
   output reg serialRxData;
   input wire [3:0] timerChanOut;
   input wire [3:0] timerChanOe;
   output reg [3:0] timerChanIn;
   input wire [4:0] analogChannelSelect;
   input wire [7:0] lcdFrontplaneOut;

   // ==========================================================
   // Storage
   reg [7:0] portALatch_q;
   reg [7:0] portBLatch_q;
   reg [7:0] portCLatch_q;
   reg [7:0] portADir_q;
   reg [7:0] portBDir_q;
   reg [7:0] portCDir_q;
   reg [5:0] portBLed_q;
   reg [6:0] altCtrl_q;
   reg [31:0] readData_d;
   reg mapped_d;
   wire [7:0] pinASync;
   wire [7:0] pinBSync;
   wire [7:0] pinCSync;
   wire [9:0] regIndex;
   wire wrEn;
   wire rdEn;
   wire serialOn;
   wire [3:0] timerOwn;
   wire [1:0] analogOwn;
   wire [7:0] lcdOwn;
   reg [7:0] bOwned;
   integer i;

   // ==========================================================
   // Pin synchronisers, one instance shared by all 24 pins of the three ports
   gpb_pin_sync #(.WIDTH(24)) uPinSync (
      .clk(clk),
      .din({portCIn, portBIn, portAIn}),
      .dout({pinCSync, pinBSync, pinASync})
   );

   // ==========================================================
   // APB decode: zero-wait slave, unmapped address flagged by pslverr
   assign regIndex = paddr[ADDR_WIDTH-1:2];
   assign pready = 1'b1;
   assign wrEn = psel & penable & pwrite;
   assign rdEn = psel & penable & ~pwrite;
   assign pslverr = psel & penable & ~mapped_d;

   // Alternate function ownership seen by port logic
   assign serialOn = altCtrl_q[`GPB_ALT_SERIAL_ON];
   assign timerOwn = altCtrl_q[`GPB_ALT_TIMER2_CHANNEL1_PIN:`GPB_ALT_TIMER1_CHANNEL0_PIN];
   assign analogOwn[0] = (analogChannelSelect == `GPB_ADC_CH4);
   assign analogOwn[1] = (analogChannelSelect == `GPB_ADC_CH5);
   assign lcdOwn = {{4{altCtrl_q[`GPB_ALT_LCD_UPPER]}},
                    {4{altCtrl_q[`GPB_ALT_LCD_LOWER]}}};

   // ==========================================================
   // Control registers with reset; direction bits start as inputs
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         portADir_q <= `GPB_DIR_RESET;
         portBDir_q <= `GPB_DIR_RESET;
         portCDir_q <= `GPB_DIR_RESET;
         portBLed_q <= `GPB_LED_RESET;
         altCtrl_q <= `GPB_ALT_RESET;
      end
      else if (wrEn)
      begin
         case (regIndex)
            {2'b00, `GPB_IDX_PORTA_DIR}: portADir_q <= pwdata[7:0];
            {2'b00, `GPB_IDX_PORTB_DIR}: portBDir_q <= pwdata[7:0];
            {2'b00, `GPB_IDX_PORTC_DIR}: portCDir_q <= pwdata[7:0];
            {2'b00, `GPB_IDX_PORTB_LED}: portBLed_q <= pwdata[5:0];
            {2'b00, `GPB_IDX_ALT_CTRL}: altCtrl_q <= pwdata[6:0];
            default: ;
         endcase
      end
   end

   // ==========================================================
   // Data latches: no reset, so contents survive a system reset
   always @(posedge clk)
   begin
      if (wrEn)
      begin
         case (regIndex)
            {2'b00, `GPB_IDX_PORTA_LATCH}: portALatch_q <= pwdata[7:0];
            {2'b00, `GPB_IDX_PORTB_LATCH}: portBLatch_q <= pwdata[7:0];
            {2'b00, `GPB_IDX_PORTC_LATCH}: portCLatch_q <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // ==========================================================
   // Read mux ignores ownership; output pins read the latch, input pins read the pad through the synchroniser
   always @*
   begin
      readData_d = 32'h00000000;
      mapped_d = 1'b1;
      case (regIndex)
         {2'b00, `GPB_IDX_PORTA_LATCH}:
            readData_d[7:0] = (portADir_q & portALatch_q) | (~portADir_q & pinASync);
         {2'b00, `GPB_IDX_PORTB_LATCH}:
            readData_d[7:0] = (portBDir_q & portBLatch_q) | (~portBDir_q & pinBSync);
         {2'b00, `GPB_IDX_PORTC_LATCH}:
            readData_d[7:0] = (portCDir_q & portCLatch_q) | (~portCDir_q & pinCSync);
         {2'b00, `GPB_IDX_PORTB_LED}:
            readData_d[7:0] = {2'b00, portBLed_q};
         {2'b00, `GPB_IDX_PORTA_DIR}: readData_d[7:0] = portADir_q;
         {2'b00, `GPB_IDX_PORTB_DIR}: readData_d[7:0] = portBDir_q;
         {2'b00, `GPB_IDX_PORTC_DIR}: readData_d[7:0] = portCDir_q;
         {2'b00, `GPB_IDX_ALT_CTRL}: readData_d[6:0] = altCtrl_q;
         default: mapped_d = 1'b0;
      endcase
   end

   // Read data driven only during a read access; zero otherwise keeps the bus quiet
   always @*
   begin
      prdata = rdEn ? readData_d : 32'h00000000;
   end

   // ==========================================================
   // Port A and C pad drive; C nibbles may belong to the LCD
   always @*
   begin
      portAOut = portALatch_q;
      portAOe = portADir_q;
      for (i = 0; i < 8; i = i + 1)
      begin
         if (lcdOwn[i])
         begin
            portCOut[i] = lcdFrontplaneOut[i];
            portCOe[i] = 1'b1;
         end
         else
         begin
            portCOut[i] = portCLatch_q[i];
            portCOe[i] = portCDir_q[i];
         end
      end
   end

   // ==========================================================
   // Port B pad drive with alternate function overrides
   // Serial wins over everything on B0/B1; timers and analog own the rest
   always @*
   begin
      bOwned = {analogOwn, timerOwn, serialOn, serialOn};
      portBOut = portBLatch_q;
      portBOe = portBDir_q;
      portBAnalog = analogOwn;
      if (serialOn)
      begin
         portBOut[0] = serialTxData;
         portBOe[0] = 1'b1;
         portBOut[1] = 1'b0;
         portBOe[1] = 1'b0;
      end
      for (i = 0; i < 4; i = i + 1)
      begin
         if (timerOwn[i])
         begin
            portBOut[i+2] = timerChanOut[i];
            portBOe[i+2] = timerChanOe[i];
         end
      end
      for (i = 0; i < 2; i = i + 1)
      begin
         if (analogOwn[i])
         begin
            portBOut[i+6] = 1'b0;
            portBOe[i+6] = 1'b0;
         end
      end
      // High sink only on an actively driven output pin
      portBHighSink = 8'h00;
      for (i = 0; i < 6; i = i + 1)
      begin
         portBHighSink[i] = portBLed_q[i] & portBDir_q[i] & ~bOwned[i];
      end
      if (serialOn)
      begin
         portBHighSink[0] = portBLed_q[0];
      end
   end

   // ==========================================================
   // Alternate inputs take the synchronised pad level
   always @*
   begin
      serialRxData = serialOn ? pinBSync[1] : 1'b1;
      timerChanIn = pinBSync[5:2];
   end
endmodule

// >>> sim/gpb_pad_model.sv
// Pad and peripheral side model of the port pins
`timescale 1ns/10ps
// ==========================================================
// Pad resolution
module gpb_pad_model (
   input logic [7:0] drvOut,
   input logic [7:0] drvOe,
   input logic [7:0] extLevel,
   output logic [7:0] padLevel
);
   // Enabled driver wins; otherwise the outside world sets the pad
   assign padLevel = (drvOe & drvOut) | (~drvOe & extLevel);
endmodule

// >>> sim/gpb_slice_properties.sv
// Concurrent checks on the port slice top ports
`timescale 1ns/10ps
`include "gpb_map.vh"
// ==========================================================
// Checker
module gpb_slice_properties #(
   parameter ADDR_WIDTH = 12
) (
   input logic clk,
   input logic sys_rst,
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [ADDR_WIDTH-1:0] paddr,
   input logic [31:0] prdata,
   input logic pready,
   input logic pslverr,
   input logic [7:0] portBOe,
   input logic [7:0] portBHighSink,
   input logic [1:0] portBAnalog,
   input logic [4:0] analogChannelSelect
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Access phase and decoded places
   wire acc = psel && penable;
   wire ledHit = paddr == ADDR_WIDTH'({`GPB_IDX_PORTB_LED, 2'b00});
   wire badHit = paddr == ADDR_WIDTH'(12'h010);
   ready_in_access_a:
   assert property (acc |-> pready) else $error("pready low in access");
   dir_reset_a:
   assert property ($fell(sys_rst) |-> portBOe == 8'h00 && portBHighSink == 8'h00)
      else $error("port B not input after reset");
   sink_top_zero_a:
   assert property (portBHighSink[7:6] == 2'b00) else $error("sink on pin 6 or 7");
   sink_needs_drive_a:
   assert property ((portBHighSink[5:1] & ~portBOe[5:1]) == 5'h00)
      else $error("sink on undriven pin");
   analog_claim_a:
   assert property (portBAnalog == {analogChannelSelect == `GPB_ADC_CH5,
      analogChannelSelect == `GPB_ADC_CH4}) else $error("analog claim wrong");
   led_read_zero_a:
   assert property (acc && !pwrite && ledHit |-> prdata[7:6] == 2'b00 && !pslverr)
      else $error("led top bits not zero");
   unmapped_err_a:
   assert property (acc && badHit |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   idle_quiet_a:
   assert property (!psel |-> !pslverr && prdata == 32'h0) else $error("idle bus not quiet");
   // Main scenarios reached
   cover property (acc && pslverr);
   cover property (portBAnalog != 2'b00);
   cover property (portBHighSink != 8'h00);
endmodule
bind gpb_port_slice gpb_slice_properties #(.ADDR_WIDTH(ADDR_WIDTH)) gpb_slice_properties_i (
   .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .portBOe(portBOe),
   .portBHighSink(portBHighSink), .portBAnalog(portBAnalog),
   .analogChannelSelect(analogChannelSelect));

// >>> sim/gpb_port_slice_tb.sv
// Self-checking bench of the port slice
`timescale 1ns/10ps
`include "gpb_map.vh"
// ==========================================================
// Bench
module gpb_port_slice_tb;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, errSeen, serialRxData;
   logic [7:0] portAIn, portAOut, portAOe, portBIn, portBOut, portBOe, portBHighSink;
   logic [7:0] portCIn, portCOut, portCOe;
   logic [7:0] extA = 8'hFF, extB = 8'h3C, extC = 8'h00, lcdFrontplaneOut = 8'h00;
   logic [1:0] portBAnalog;
   logic serialTxData = 1'b1;
   logic [3:0] timerChanOut = 4'h0, timerChanOe = 4'h0, timerChanIn;
   logic [4:0] analogChannelSelect = 5'h00;
   int n_errors = 0, n_tests = 0, cyc = 0;
   // Clock
   always #12.5 clk = ~clk;
   gpb_port_slice gpb_port_slice_i (.clk(clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .portAIn(portAIn), .portAOut(portAOut),
      .portAOe(portAOe), .portBIn(portBIn), .portBOut(portBOut), .portBOe(portBOe),
      .portBHighSink(portBHighSink), .portBAnalog(portBAnalog), .portCIn(portCIn),
      .portCOut(portCOut), .portCOe(portCOe), .serialTxData(serialTxData),
      .serialRxData(serialRxData), .timerChanOut(timerChanOut), .timerChanOe(timerChanOe),
      .timerChanIn(timerChanIn), .analogChannelSelect(analogChannelSelect),
      .lcdFrontplaneOut(lcdFrontplaneOut));
   gpb_pad_model padA (.drvOut(portAOut), .drvOe(portAOe), .extLevel(extA), .padLevel(portAIn));
   gpb_pad_model padB (.drvOut(portBOut), .drvOe(portBOe), .extLevel(extB), .padLevel(portBIn));
   gpb_pad_model padC (.drvOut(portCOut), .drvOe(portCOe), .extLevel(extC), .padLevel(portCIn));
   // ==========================================================
   // Tasks
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One APB transfer; an idle edge after it keeps strobes from being set twice
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      int w;
      w = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
         w++;
      end
      while (pready !== 1'b1 && w < 50);
      if (pready !== 1'b1)
         n_errors++;
      rd = prdata;
      errSeen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr8(input logic [7:0] idx, input logic [7:0] d);
      apb(1'b1, idx, {24'h0, d});
   endtask
   task automatic rd8(input string nm, input logic [7:0] idx, input logic [7:0] exp);
      apb(1'b0, idx, 32'h0);
      chk(nm, rd, {24'h0, exp});
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Hang guard, far above the fewer than one hundred cycles the sequence needs
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         n_errors++;
         print_verdict();
      end
   end
   // ==========================================================
   // Sequence
   initial
   begin
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      rd8("dirB", `GPB_IDX_PORTB_DIR, 8'h00);
      rd8("led", `GPB_IDX_PORTB_LED, 8'h00);
      wr8(`GPB_IDX_PORTB_LATCH, 8'hA5);
      wr8(`GPB_IDX_PORTA_LATCH, 8'h5A);
      wr8(`GPB_IDX_PORTC_LATCH, 8'h33);
      rd8("pinB", `GPB_IDX_PORTB_LATCH, 8'h3C);
      wr8(`GPB_IDX_PORTB_DIR, 8'hF0);
      rd8("dirB", `GPB_IDX_PORTB_DIR, 8'hF0);
      chk("oeB", portBOe, 8'hF0);
      rd8("mixB", `GPB_IDX_PORTB_LATCH, 8'hAC);
      wr8(`GPB_IDX_PORTA_DIR, 8'h0F);
      rd8("mixA", `GPB_IDX_PORTA_LATCH, 8'hFA);
      chk("oeA", portAOe, 8'h0F);
      chk("outA", portAOut, 8'h5A);
      wr8(`GPB_IDX_PORTC_DIR, 8'hFF);
      rd8("latC", `GPB_IDX_PORTC_LATCH, 8'h33);
      // Second reset: latches must survive it
      sys_rst <= 1'b1;
      @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      wr8(`GPB_IDX_PORTB_DIR, 8'hFF);
      rd8("keepB", `GPB_IDX_PORTB_LATCH, 8'hA5);
      wr8(`GPB_IDX_PORTC_DIR, 8'hFF);
      rd8("keepC", `GPB_IDX_PORTC_LATCH, 8'h33);
      wr8(`GPB_IDX_PORTB_LED, 8'hFF);
      rd8("led", `GPB_IDX_PORTB_LED, 8'h3F);
      chk("sink", portBHighSink, 8'h3F);
      // Serial unit takes pins 0 and 1
      serialTxData <= 1'b0;
      extB <= 8'h00;
      wr8(`GPB_IDX_ALT_CTRL, 8'h01);
      // Pin reads lag the pad by the two synchroniser stages
      repeat (3) @(posedge clk);
      chk("serOe", portBOe[1:0], 2'b01);
      chk("txOut", portBOut[0], 1'b0);
      chk("rx", serialRxData, 1'b0);
      chk("txSink", portBHighSink[0], 1'b1);
      // Timers take pins 2 to 5
      timerChanOe <= 4'hF;
      timerChanOut <= 4'h5;
      wr8(`GPB_IDX_ALT_CTRL, 8'h1E);
      repeat (3) @(posedge clk);
      chk("tmrOut", portBOut[5:2], 4'h5);
      chk("tmrIn", timerChanIn, 4'h5);
      chk("tmrSink", portBHighSink[5:2], 4'h0);
      // Frontplane nibbles of port C
      lcdFrontplaneOut <= 8'h5A;
      wr8(`GPB_IDX_ALT_CTRL, 8'h40);
      chk("lcdUp", portCOut, 8'h53);
      wr8(`GPB_IDX_ALT_CTRL, 8'h20);
      chk("lcdLo", portCOut, 8'h3A);
      // Analog claims of pins 6 and 7
      analogChannelSelect <= `GPB_ADC_CH4;
      @(posedge clk);
      chk("adc4", portBAnalog, 2'b01);
      analogChannelSelect <= `GPB_ADC_CH5;
      @(posedge clk);
      chk("adc5", portBAnalog, 2'b10);
      // Unmapped place is refused
      rd8("bad", 8'h04, 8'h00);
      chk("badErr", errSeen, 1'b1);
      print_verdict();
   end
endmodule
